// file: bench/capture_compare_timer_test.sv
// Self-checking bench of the capture/compare timer over AXI4-Lite.
// Assumes the pulse source model drives the trigger and auxiliary lines.
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin mismatches++; \
   $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module capture_compare_timer_test;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, t0, t1, aux, pin, ext_irq_a, ext_irq_b, irq, mb;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int mismatches, comparisons, na, nb, nm;
   cct_pulse_source cct_pulse_source_inst (.aclk, .trig_zero(t0), .trig_one(t1), .aux_tog(aux));
   cct_capture_timer cct_capture_timer_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .trigger_input_zero(t0), .trigger_input_one(t1), .aux_timer_toggle(aux), .toggle_output_pin(pin),
      .ext_irq_a, .ext_irq_b, .match_b_irq(mb), .irq);
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      na <= na + int'(ext_irq_a);
      nb <= nb + int'(ext_irq_b);
      nm <= nm + int'(mb);
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do @(posedge aclk); while (s_axi_awready !== 1'b1);
      {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd
   // Two edges five cycles apart must leave captures five counts apart, whatever the counter held.
   task automatic cap_pair(input logic [1:0] m);
      logic [31:0] ca, cb;
      logic [1:0] r;
      int a0, b0;
      wr(cct_pkg::OFS_MODE, {27'h0, m, 3'h1});
      a0 = na;
      b0 = nb;
      cct_pulse_source_inst.drive(m == cct_pkg::CAPM_AUX ? 2 : 0, 1'b1);
      repeat (4) @(posedge aclk);
      // The pulse counters update on the fourth edge, so look just after it.
      #1;
      `CHK(na - a0, int'(m == cct_pkg::CAPM_RISE))
      cct_pulse_source_inst.drive(m == cct_pkg::CAPM_RISE ? 1 : (m == cct_pkg::CAPM_AUX ? 2 : 0),
                                  m == cct_pkg::CAPM_RISE);
      repeat (4) @(posedge aclk);
      #1;
      `CHK(na - a0, int'(m != cct_pkg::CAPM_AUX))
      `CHK(nb - b0, int'(m == cct_pkg::CAPM_RISE))
      `CHK(irq, m == cct_pkg::CAPM_RISE)
      rd(cct_pkg::OFS_CAP_A, ca, r);
      rd(cct_pkg::OFS_CAP_B, cb, r);
      `CHK(cb[15:0] - ca[15:0], 16'h0005)
      cct_pulse_source_inst.drive(0, 1'b0);
      cct_pulse_source_inst.drive(1, 1'b0);
      wr(cct_pkg::OFS_IRQ_STAT, 32'hf);
      `CHK(irq, 1'b0)
   endtask : cap_pair
   task automatic tog_test;
      wr(cct_pkg::OFS_MODE, 32'h9);
      wr(cct_pkg::OFS_TOGGLE, 32'h10);
      `CHK(pin, 1'b1)
      wr(cct_pkg::OFS_TOGGLE, 32'h24);
      `CHK(pin, 1'b0)
      cct_pulse_source_inst.drive(0, 1'b1);
      repeat (4) @(posedge aclk);
      `CHK(pin, 1'b1)
      cct_pulse_source_inst.drive(0, 1'b0);
      wr(cct_pkg::OFS_TOGGLE, 32'h20);
      `CHK(pin, 1'b0)
   endtask : tog_test
   // Counting trigger zero rises: matches at count+2 and count+3 invert the pin twice.
   task automatic cmp_test;
      logic [31:0] c, d;
      logic [1:0] r;
      int m0;
      wr(cct_pkg::OFS_MODE, 32'h3);
      rd(cct_pkg::OFS_COUNT, c, r);
      wr(cct_pkg::OFS_CMP_A, c + 32'h2);
      wr(cct_pkg::OFS_CMP_B, c + 32'h3);
      wr(cct_pkg::OFS_TOGGLE, 32'h23);
      `CHK(pin, 1'b0)
      m0 = nm;
      for (int i = 1; i < 4; i++) begin
         cct_pulse_source_inst.drive(0, 1'b1);
         repeat (2) @(posedge aclk);
         cct_pulse_source_inst.drive(0, 1'b0);
         repeat (4) @(posedge aclk);
         #1;
         `CHK(pin, i == 2)
      end
      `CHK(nm - m0, 1)
      rd(cct_pkg::OFS_COUNT, d, r);
      `CHK(d - c, 32'h3)
   endtask : cmp_test
   task automatic bad_addr;
      logic [31:0] d;
      logic [1:0] r;
      rd(8'h40, d, r);
      `CHK(r, cct_pkg::RESP_SLVERR)
      `CHK(d, 32'h0)
   endtask : bad_addr
   ////////////////////////////////////////////////////////////////////////////////
   task automatic stop_test;
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : stop_test
   initial begin
      #50000;
      mismatches++;
      stop_test;
   end
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, aresetn} = 6'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      {na, nb, nm, mismatches, comparisons} = '0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      wr(cct_pkg::OFS_IRQ_MASK, 32'h2);
      for (int m = 1; m < 4; m++) cap_pair(2'(m));
      tog_test;
      cmp_test;
      bad_addr;
      stop_test;
   end
endmodule : capture_compare_timer_test

// file: bench/cct_pulse_source.sv
// Model of the external trigger pulse sources and the auxiliary timer flip-flop.
// Assumes the bench calls drive() and that every line is a level sampled on aclk.
`timescale 1ns/1ps
module cct_pulse_source (
   input  wire logic aclk,      // system clock
   output logic      trig_zero, // trigger input zero
   output logic      trig_one,  // trigger input one
   output logic      aux_tog    // auxiliary timer flip-flop
);
   initial {trig_zero, trig_one, aux_tog} = 3'h0;
   // Lines move only just after an edge, so no capture depends on a race.
   task automatic drive(input int line, input logic v);
      @(posedge aclk);
      case (line)
         0: trig_zero <= v;
         1: trig_one <= v;
         default: aux_tog <= v;
      endcase
   endtask : drive
endmodule : cct_pulse_source

// file: pkg/cct_pkg.sv
// Shared constants and types of the capture/compare timer.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
package cct_pkg;

   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;

   // Register byte offsets.
   localparam logic [7:0] OFS_MODE     = 8'h00;
   localparam logic [7:0] OFS_TOGGLE   = 8'h04;
   localparam logic [7:0] OFS_CMP_A    = 8'h08;
   localparam logic [7:0] OFS_CMP_B    = 8'h0c;
   localparam logic [7:0] OFS_CAP_A    = 8'h10;
   localparam logic [7:0] OFS_CAP_B    = 8'h14;
   localparam logic [7:0] OFS_COUNT    = 8'h18;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h1c;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
   localparam logic [7:0] OFS_PRESCALE = 8'h24;

   // Capture mode field encodings.
   localparam logic [1:0] CAPM_OFF   = 2'h0;
   localparam logic [1:0] CAPM_RISE  = 2'h1;
   localparam logic [1:0] CAPM_PULSE = 2'h2;
   localparam logic [1:0] CAPM_AUX   = 2'h3;

   // Toggle flip-flop software actions, write-only bits 5:4 of the toggle control register.
   localparam logic [1:0] ACT_INVERT = 2'h0;
   localparam logic [1:0] ACT_SET    = 2'h1;
   localparam logic [1:0] ACT_CLEAR  = 2'h2;
   localparam logic [1:0] ACT_NONE   = 2'h3;
   localparam int unsigned ACT_LSB   = 4;

   // Interrupt status and mask bit positions.
   localparam int unsigned IRQ_EXT_A   = 0;
   localparam int unsigned IRQ_EXT_B   = 1;
   localparam int unsigned IRQ_MATCH_B = 2;
   localparam int unsigned IRQ_MATCH_A = 3;
   localparam int unsigned IRQ_W       = 4;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [1:0] capture_mode_field;
      logic       clear_on_match_b;
      logic       ext_clock;
      logic       run;
   } cct_mode_t;

   typedef struct packed {
      logic cap_b_toggle_enable;
      logic cap_a_toggle_enable;
      logic match_b_toggle_enable;
      logic match_a_toggle_enable;
   } cct_toggle_t;

   localparam cct_mode_t   MODE_RST     = 5'h00;
   localparam cct_toggle_t TOGGLE_RST   = 4'h0;
   localparam logic [7:0]  PRESCALE_RST = 8'h00;

endpackage : cct_pkg

// file: verilog/cct_capture_timer.sv
// Capture/compare timer: free-running up-counter, two capture and two compare registers,
// a toggle flip-flop with output pin, and an AXI4-Lite register slave with interrupts.
// Assumes trigger inputs are synchronous levels sampled on aclk; pulses last two cycles or more.
//
// Operation
// - rise and pulse modes: trigger zero rise latches counter into capture A
// - both match enables invert toggle on each match
// - capture-load toggle option inverts on capture A
// - non pulse modes: ext irq A on rise
// - pulse mode: ext irq A on falling edge
// - pulse mode: rise to A, fall to B
// - aux mode: aux rise to A, fall B
// - time difference: trigger one rise captures B
// - trigger one capture raises ext irq B
// - counter may be clocked by trigger zero
// - clear action zeroes toggle, wins over enabled inversions that cycle
// - enables clear: matches leave toggle unchanged
// - sixteen-bit registers, counter free-runs through captures
// - external clock advances counter on each rise
// - compare value zero matches on overflow
// - toggle flip-flop drives the output pin
// - compare B match raises timer interrupt
`timescale 1ns/1ps
module cct_capture_timer #(
   parameter int unsigned CNT_W = 16,   // counter and capture/compare width
   parameter int unsigned PRE_W = 8     // prescaler reload width
) (
   input  wire logic                       aclk,                // system clock
   input  wire logic                       aresetn,             // synchronous reset, low
   input  wire logic [cct_pkg::ADDR_W-1:0] s_axi_awaddr,        // write address
   input  wire logic                       s_axi_awvalid,       // write address valid
   output logic                            s_axi_awready,       // write address ready
   input  wire logic [cct_pkg::DATA_W-1:0] s_axi_wdata,         // write data
   input  wire logic [3:0]                 s_axi_wstrb,         // write byte enables
   input  wire logic                       s_axi_wvalid,        // write data valid
   output logic                            s_axi_wready,        // write data ready
   output logic [1:0]                      s_axi_bresp,         // write response
   output logic                            s_axi_bvalid,        // write response valid
   input  wire logic                       s_axi_bready,        // write response ready
   input  wire logic [cct_pkg::ADDR_W-1:0] s_axi_araddr,        // read address
   input  wire logic                       s_axi_arvalid,       // read address valid
   output logic                            s_axi_arready,       // read address ready
   output logic [cct_pkg::DATA_W-1:0]      s_axi_rdata,         // read data
   output logic [1:0]                      s_axi_rresp,         // read response
   output logic                            s_axi_rvalid,        // read data valid
   input  wire logic                       s_axi_rready,        // read data ready
   input  wire logic                       trigger_input_zero,  // capture trigger / external clock
   input  wire logic                       trigger_input_one,   // second capture trigger
   input  wire logic                       aux_timer_toggle,    // auxiliary timer flip-flop
   output logic                            toggle_output_pin,   // toggle flip-flop state
   output logic                            ext_irq_a,           // trigger A interrupt pulse
   output logic                            ext_irq_b,           // trigger B interrupt pulse
   output logic                            match_b_irq,         // compare B match pulse
   output logic                            irq                  // masked sticky interrupt level
);

   generate
      if (CNT_W < 2 || CNT_W > 32 || PRE_W < 1 || PRE_W > 8) begin : g_bad_param
         $error("cct_capture_timer: CNT_W must be 2..32 and PRE_W 1..8");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Input synchronisers and edge detectors: bit 0 trigger zero, 1 trigger one, 2 aux.

   logic [2:0] sync_meta;
   logic [2:0] sync_q;
   logic [2:0] sync_d;
   logic [2:0] edge_rise;
   logic [2:0] edge_fall;
   wire  [2:0] ext_in = {aux_timer_toggle, trigger_input_one, trigger_input_zero};

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_sync
         // The meta flop feeds only the second stage; edges come from stages two and three.
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               sync_meta[gi] <= 1'b0;
               sync_q[gi]    <= 1'b0;
               sync_d[gi]    <= 1'b0;
            end else begin
               sync_meta[gi] <= ext_in[gi];
               sync_q[gi]    <= sync_meta[gi];
               sync_d[gi]    <= sync_q[gi];
            end
         end
         assign edge_rise[gi] = sync_q[gi] & ~sync_d[gi];
         assign edge_fall[gi] = ~sync_q[gi] & sync_d[gi];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Registers.

   cct_pkg::cct_mode_t          timer_mode_reg;
   cct_pkg::cct_toggle_t        toggle_control_reg;
   logic [CNT_W-1:0]            compare_reg_a;
   logic [CNT_W-1:0]            compare_reg_b;
   logic [CNT_W-1:0]            capture_reg_a;
   logic [CNT_W-1:0]            capture_reg_b;
   logic [CNT_W-1:0]            main_up_counter;
   logic [PRE_W-1:0]            prescale;
   logic [PRE_W-1:0]            pre_cnt;
   logic                        toggle_flipflop;
   logic [cct_pkg::IRQ_W-1:0]   irq_status;
   logic [cct_pkg::IRQ_W-1:0]   irq_mask;

   function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] data,
                                               input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = data[b*8 +: 8];
         end
      end
      return res;
   endfunction : merge_bytes

   ////////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite handshakes: one write and one read at a time, each answered one cycle after it is taken.

   wire wr_take = s_axi_awready & s_axi_awvalid & s_axi_wvalid;
   wire rd_take = s_axi_arready & s_axi_arvalid;
   wire next_awready = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
   wire next_arready = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;

   wire wsel_mode   = (s_axi_awaddr == cct_pkg::OFS_MODE);
   wire wsel_toggle = (s_axi_awaddr == cct_pkg::OFS_TOGGLE);
   wire wsel_cmp_a  = (s_axi_awaddr == cct_pkg::OFS_CMP_A);
   wire wsel_cmp_b  = (s_axi_awaddr == cct_pkg::OFS_CMP_B);
   wire wsel_stat   = (s_axi_awaddr == cct_pkg::OFS_IRQ_STAT);
   wire wsel_mask   = (s_axi_awaddr == cct_pkg::OFS_IRQ_MASK);
   wire wsel_pre    = (s_axi_awaddr == cct_pkg::OFS_PRESCALE);
   wire wsel_ro     = (s_axi_awaddr == cct_pkg::OFS_CAP_A) | (s_axi_awaddr == cct_pkg::OFS_CAP_B) |
                      (s_axi_awaddr == cct_pkg::OFS_COUNT);
   wire wr_mapped   = wsel_mode | wsel_toggle | wsel_cmp_a | wsel_cmp_b | wsel_stat | wsel_mask |
                      wsel_pre | wsel_ro;

   wire [31:0] wr_mode   = merge_bytes(32'(timer_mode_reg), s_axi_wdata, s_axi_wstrb);
   wire [31:0] wr_toggle = merge_bytes(32'(toggle_control_reg), s_axi_wdata, s_axi_wstrb);
   wire [31:0] wr_cmp_a  = merge_bytes(32'(compare_reg_a), s_axi_wdata, s_axi_wstrb);
   wire [31:0] wr_cmp_b  = merge_bytes(32'(compare_reg_b), s_axi_wdata, s_axi_wstrb);
   wire [31:0] wr_mask   = merge_bytes(32'(irq_mask), s_axi_wdata, s_axi_wstrb);
   wire [31:0] wr_pre    = merge_bytes(32'(prescale), s_axi_wdata, s_axi_wstrb);

   wire        toggle_wr  = wr_take & wsel_toggle & s_axi_wstrb[0];
   wire [1:0]  toggle_act = s_axi_wdata[cct_pkg::ACT_LSB +: 2];
   wire [cct_pkg::IRQ_W-1:0] stat_clr = (wr_take & wsel_stat & s_axi_wstrb[0]) ?
                                        s_axi_wdata[cct_pkg::IRQ_W-1:0] : '0;

   wire rsel_mode   = (s_axi_araddr == cct_pkg::OFS_MODE);
   wire rsel_toggle = (s_axi_araddr == cct_pkg::OFS_TOGGLE);
   wire rsel_cmp_a  = (s_axi_araddr == cct_pkg::OFS_CMP_A);
   wire rsel_cmp_b  = (s_axi_araddr == cct_pkg::OFS_CMP_B);
   wire rsel_cap_a  = (s_axi_araddr == cct_pkg::OFS_CAP_A);
   wire rsel_cap_b  = (s_axi_araddr == cct_pkg::OFS_CAP_B);
   wire rsel_count  = (s_axi_araddr == cct_pkg::OFS_COUNT);
   wire rsel_stat   = (s_axi_araddr == cct_pkg::OFS_IRQ_STAT);
   wire rsel_mask   = (s_axi_araddr == cct_pkg::OFS_IRQ_MASK);
   wire rsel_pre    = (s_axi_araddr == cct_pkg::OFS_PRESCALE);
   wire rd_mapped   = rsel_mode | rsel_toggle | rsel_cmp_a | rsel_cmp_b | rsel_cap_a | rsel_cap_b |
                      rsel_count | rsel_stat | rsel_mask | rsel_pre;

   // The action field is write-only and reads back as the no-action code.
   wire [31:0] rd_toggle = 32'(toggle_control_reg) | 32'({cct_pkg::ACT_NONE, 4'h0});
   wire [31:0] rd_mux =
      rsel_mode   ? 32'(timer_mode_reg) :
      rsel_toggle ? rd_toggle :
      rsel_cmp_a  ? 32'(compare_reg_a) :
      rsel_cmp_b  ? 32'(compare_reg_b) :
      rsel_cap_a  ? 32'(capture_reg_a) :
      rsel_cap_b  ? 32'(capture_reg_b) :
      rsel_count  ? 32'(main_up_counter) :
      rsel_stat   ? 32'(irq_status) :
      rsel_mask   ? 32'(irq_mask) :
      rsel_pre    ? 32'(prescale) : 32'h0000_0000;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= cct_pkg::RESP_OKAY;
      end else begin
         s_axi_awready <= next_awready;
         s_axi_wready  <= next_awready;
         if (wr_take) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_mapped ? cct_pkg::RESP_OKAY : cct_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= cct_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= next_arready;
         if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_mapped ? cct_pkg::RESP_OKAY : cct_pkg::RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timer_mode_reg     <= cct_pkg::MODE_RST;
         toggle_control_reg <= cct_pkg::TOGGLE_RST;
         compare_reg_a      <= '0;
         compare_reg_b      <= '0;
         irq_mask           <= '0;
         prescale           <= cct_pkg::PRESCALE_RST[PRE_W-1:0];
      end else if (wr_take) begin
         if (wsel_mode)   timer_mode_reg     <= wr_mode[$bits(cct_pkg::cct_mode_t)-1:0];
         if (wsel_toggle) toggle_control_reg <= wr_toggle[$bits(cct_pkg::cct_toggle_t)-1:0];
         if (wsel_cmp_a)  compare_reg_a      <= wr_cmp_a[CNT_W-1:0];
         if (wsel_cmp_b)  compare_reg_b      <= wr_cmp_b[CNT_W-1:0];
         if (wsel_mask)   irq_mask           <= wr_mask[cct_pkg::IRQ_W-1:0];
         if (wsel_pre)    prescale           <= wr_pre[PRE_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Counter, captures and compares.

   wire [1:0] cap_mode = timer_mode_reg.capture_mode_field;
   wire       pre_tick = (pre_cnt == prescale);
   // Trigger zero as counter clock counts events instead of prescaler ticks.
   wire       count_tick = timer_mode_reg.run &
                           (timer_mode_reg.ext_clock ? edge_rise[0] : pre_tick);
   wire [CNT_W-1:0] count_inc = main_up_counter + CNT_W'(1);
   // Matching on the incremented value makes a zero compare fire at the wrap.
   wire match_a = count_tick & (count_inc == compare_reg_a);
   wire match_b = count_tick & (count_inc == compare_reg_b);
   wire [CNT_W-1:0] next_counter = (match_b & timer_mode_reg.clear_on_match_b) ? '0 : count_inc;

   wire cap_a_evt = ((cap_mode == cct_pkg::CAPM_RISE | cap_mode == cct_pkg::CAPM_PULSE) & edge_rise[0]) |
                    ((cap_mode == cct_pkg::CAPM_AUX) & edge_rise[2]);
   wire cap_b_evt = ((cap_mode == cct_pkg::CAPM_RISE) & edge_rise[1]) |
                    ((cap_mode == cct_pkg::CAPM_PULSE) & edge_fall[0]) |
                    ((cap_mode == cct_pkg::CAPM_AUX) & edge_fall[2]);
   wire ext_a_evt = (cap_mode == cct_pkg::CAPM_PULSE) ? edge_fall[0] : edge_rise[0];
   wire ext_b_evt = (cap_mode == cct_pkg::CAPM_RISE) & edge_rise[1];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pre_cnt <= '0;
      end else if (!timer_mode_reg.run || pre_tick) begin
         pre_cnt <= '0;
      end else begin
         pre_cnt <= pre_cnt + PRE_W'(1);
      end
   end

   // Captures sample the counter without disturbing it; a wrap leaves them alone.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         main_up_counter <= '0;
         capture_reg_a   <= '0;
         capture_reg_b   <= '0;
      end else begin
         if (count_tick) main_up_counter <= next_counter;
         if (cap_a_evt)  capture_reg_a   <= main_up_counter;
         if (cap_b_evt)  capture_reg_b   <= main_up_counter;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Toggle flip-flop: a software action wins over hardware inversions in the same cycle.

   wire flips = (match_a & toggle_control_reg.match_a_toggle_enable) ^
                (match_b & toggle_control_reg.match_b_toggle_enable) ^
                (cap_a_evt & toggle_control_reg.cap_a_toggle_enable) ^
                (cap_b_evt & toggle_control_reg.cap_b_toggle_enable);
   wire next_toggle =
      (toggle_wr && toggle_act == cct_pkg::ACT_CLEAR)  ? 1'b0 :
      (toggle_wr && toggle_act == cct_pkg::ACT_SET)    ? 1'b1 :
      (toggle_wr && toggle_act == cct_pkg::ACT_INVERT) ? ~toggle_flipflop :
      toggle_flipflop ^ flips;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         toggle_flipflop <= 1'b0;
      end else begin
         toggle_flipflop <= next_toggle;
      end
   end

   assign toggle_output_pin = toggle_flipflop;

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupts: a new event beats a write-one-to-clear in the same cycle.

   wire [cct_pkg::IRQ_W-1:0] irq_events = {match_a, match_b, ext_b_evt, ext_a_evt};
   wire [cct_pkg::IRQ_W-1:0] next_status = (irq_status & ~stat_clr) | irq_events;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status  <= '0;
         irq         <= 1'b0;
         ext_irq_a   <= 1'b0;
         ext_irq_b   <= 1'b0;
         match_b_irq <= 1'b0;
      end else begin
         irq_status  <= next_status;
         irq         <= |(next_status & irq_mask);
         ext_irq_a   <= ext_a_evt;
         ext_irq_b   <= ext_b_evt;
         match_b_irq <= match_b;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   cap_a_latch_a: assert property (cap_a_evt |=> capture_reg_a == $past(main_up_counter))
      else $error("capture A did not take the counter value");
   toggle_flip_a: assert property (!toggle_wr |=> toggle_flipflop == ($past(toggle_flipflop) ^ $past(flips)))
      else $error("toggle flip-flop did not follow enabled events");
   toggle_clear_a: assert property (toggle_wr && toggle_act == cct_pkg::ACT_CLEAR |=> !toggle_output_pin)
      else $error("clear action left toggle set");
   irq_a_rise_a: assert property (edge_rise[0] && cap_mode != cct_pkg::CAPM_PULSE
                                  |=> ext_irq_a && irq_status[cct_pkg::IRQ_EXT_A])
      else $error("ext irq A missing on rising edge");
   irq_a_fall_a: assert property (edge_fall[0] && cap_mode == cct_pkg::CAPM_PULSE |=> ext_irq_a)
      else $error("ext irq A missing on falling edge in pulse mode");
   pulse_cap_b_a: assert property (edge_fall[0] && cap_mode == cct_pkg::CAPM_PULSE
                                   |=> capture_reg_b == $past(main_up_counter))
      else $error("pulse mode fall did not capture into B");
   aux_cap_b_a: assert property (edge_fall[2] && cap_mode == cct_pkg::CAPM_AUX
                                 |=> capture_reg_b == $past(main_up_counter))
      else $error("aux fall did not capture into B");
   diff_cap_b_a: assert property (edge_rise[1] && cap_mode == cct_pkg::CAPM_RISE
                                  |=> capture_reg_b == $past(main_up_counter) && ext_irq_b)
      else $error("trigger one rise did not capture B with irq");
   ext_count_a: assert property (timer_mode_reg.run && timer_mode_reg.ext_clock && edge_rise[0] &&
                                 !(match_b && timer_mode_reg.clear_on_match_b)
                                 |=> main_up_counter == $past(count_inc))
      else $error("external clock edge did not advance counter");
   wrap_keep_a: assert property (count_tick && main_up_counter == '1 && !cap_a_evt && !cap_b_evt
                                 |=> main_up_counter == '0 && $stable(capture_reg_a) && $stable(capture_reg_b))
      else $error("wrap disturbed counter or captures");
   cmp_zero_a: assert property (count_tick && main_up_counter == '1 && compare_reg_b == '0
                                |=> match_b_irq)
      else $error("zero compare did not match on overflow");
   sync_edge_a: assert property ($rose(trigger_input_zero) |-> ##2 edge_rise[0])
      else $error("synchronised edge not seen two cycles later");

   cov_pulse_c: cover property (cap_mode == cct_pkg::CAPM_PULSE && edge_rise[0] ##[1:200] edge_fall[0]);
   cov_aux_c: cover property (cap_mode == cct_pkg::CAPM_AUX && cap_b_evt);
   cov_toggle_c: cover property (match_a && toggle_control_reg.match_a_toggle_enable ##[1:500] match_b);
   cov_irq_c: cover property ($rose(irq));

endmodule : cct_capture_timer
